/* serial_peer.sv */
/*
 * remote serial transmitter model driving the receive line of the channel.
 * assumes 10 ref_clk cycles per 16x tick, so one bit lasts 160 cycles.
 */
module serial_peer (
   input wire logic ref_clk,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT_CYC = 160;

   // line idles at mark between frames
   initial rxd = 1'b1;

   // change just after an edge, then hold for a whole bit time
   task automatic put(input logic b);
      rxd <= b;
      repeat (BIT_CYC) @(posedge ref_clk);
   endtask

   // lsb first; ninth bit is parity or address tag; low stop makes a bad frame
   task automatic send(input logic [7:0] d, input logic has9, input logic b9,
         input logic stop);
      @(posedge ref_clk);
      put(1'b0);
      for (int i = 0; i < 8; i++) begin
         put(d[i]);
      end
      if (has9) begin
         put(b9);
      end
      put(stop);
      // a full mark bit so a break is released before the next start
      put(1'b1);
   endtask
endmodule

/* uart_rx_fifo_loop.sv */
/*
 * receive fifo, error modes, flow control, loop modes and multidrop tagging
 * of one serial channel, with a minimal transmitter for normal output and local loopback.
 * assumes rxd is synchronous to ref_clk and the apb master holds requests.
 */
module uart_rx_fifo_loop (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire uart_rx_pkg::apb_req_t apb_req,
   output uart_rx_pkg::apb_rsp_t apb_rsp,
   input wire logic rxd,
   output logic txd,
   output logic rts_n,
   output logic rx_irq
);
   import uart_rx_pkg::*;

   typedef struct packed {
      logic [7:0] mr1;
      logic [7:0] aux;
      loop_t loop_act;
      logic echo_wait;
      logic [3:0] echo_cnt;
      logic rx_en;
      logic tx_en;
      entry_t [2:0] fifo;
      logic [1:0] cnt;
      entry_t hold;
      logic hold_v;
      logic oe;
      logic [2:0] acc;
      logic rts_n;
      logic irq;
      logic [3:0] div;
      logic tick;
      rx_state_t rst;
      logic [3:0] rsc;
      logic [3:0] rbits;
      logic [7:0] rsh;
      logic rpar;
      tx_state_t tst;
      logic [3:0] tsc;
      logic [3:0] tbits;
      logic [7:0] tsh;
      logic tpar;
      logic [7:0] tbuf;
      logic tbuf_v;
      logic tline;
      logic txd;
      logic pop_arm;
      apb_rsp_t rsp;
   } st_t;

   st_t s_reg;
   st_t s_next;
   logic rx_in;
   logic access;
   logic done;
   logic start_ok;
   logic stop_ev;
   logic multi;
   logic rts_rx_ctl;

   assign apb_rsp = s_reg.rsp;
   assign txd = s_reg.txd;
   assign rts_n = s_reg.rts_n;
   assign rx_irq = s_reg.irq;

   always_comb begin
      st_t n;
      loop_t req;
      entry_t e;
      logic has9;
      logic popped;
      logic accept;
      logic [7:0] stat;
      logic [2:0] flags;
      n = s_reg;
      req = LOOP_NONE;
      e = '0;
      has9 = 1'b0;
      popped = 1'b0;
      accept = 1'b0;
      stat = 8'h00;
      flags = 3'h0;
      n.tick = 1'b0;
      n.div = s_reg.div + 4'h1;
      if (s_reg.div == DIV16) begin
         n.div = 4'h0;
         n.tick = 1'b1;
      end
      multi = (s_reg.mr1[4:3] == PM_MULTI);
      has9 = (s_reg.mr1[4:3] != PM_NONE);
      // receiver alone steers rts only when the transmitter does not
      rts_rx_ctl = s_reg.mr1[MR1_RXRTS] & ~s_reg.aux[AUX_TXRTS];
      rx_in = (s_reg.loop_act == LOOP_LOCAL) ? s_reg.tline : rxd;
      access = apb_req.psel & apb_req.penable;
      done = access & s_reg.rsp.pready;
      start_ok = 1'b0;
      stop_ev = 1'b0;

      // bus slave: one wait state, answer prepared from current state
      n.rsp.pready = access & ~s_reg.rsp.pready;
      if (access && !s_reg.rsp.pready) begin
         n.rsp.prdata = 32'h0000_0000;
         n.rsp.pslverr = 1'b0;
         n.pop_arm = 1'b0;
         flags = s_reg.mr1[MR1_BLOCK] ? s_reg.acc :
            ((s_reg.cnt != 2'h0) ? {s_reg.fifo[0].rb, s_reg.fifo[0].fe, s_reg.fifo[0].pe}
             : 3'h0);
         stat = {flags, s_reg.oe,
                 s_reg.tst == T_IDLE && !s_reg.tbuf_v && s_reg.tx_en,
                 !s_reg.tbuf_v && s_reg.tx_en,
                 s_reg.cnt == FIFO_DEPTH, s_reg.cnt != 2'h0};
         if (s_reg.loop_act == LOOP_ECHO) begin
            stat[3:2] = 2'h0;
         end
         if (s_reg.loop_act == LOOP_REMOTE) begin
            stat = 8'h00;
         end
         unique case (apb_req.paddr)
            ADDR_MODE1: n.rsp.prdata = {24'h00_0000, s_reg.mr1};
            ADDR_STATUS: n.rsp.prdata = {24'h00_0000, stat};
            ADDR_CMD: n.rsp.prdata = 32'h0000_0000;
            ADDR_DATA: begin
               if (s_reg.cnt != 2'h0 && s_reg.loop_act != LOOP_REMOTE) begin
                  n.rsp.prdata = {24'h00_0000, s_reg.fifo[0].data};
                  n.pop_arm = ~apb_req.pwrite;
               end
            end
            ADDR_AUX: n.rsp.prdata = {24'h00_0000, s_reg.aux};
            default: n.rsp.pslverr = 1'b1;
         endcase
      end

      // reset-error clear comes first so a same-cycle arrival still sets
      if (done && apb_req.pwrite && apb_req.paddr == ADDR_CMD &&
          apb_req.pwdata[6:4] == MISC_RST_ERR) begin
         n.acc = 3'h0;
         n.oe = 1'b0;
      end
      if (done && apb_req.pwrite) begin
         unique case (apb_req.paddr)
            ADDR_MODE1: n.mr1 = apb_req.pwdata[7:0];
            ADDR_AUX: n.aux = apb_req.pwdata[7:0];
            ADDR_DATA: begin
               if (s_reg.loop_act != LOOP_ECHO && s_reg.loop_act != LOOP_REMOTE) begin
                  n.tbuf = apb_req.pwdata[7:0];
                  n.tbuf_v = 1'b1;
               end
            end
            ADDR_CMD: begin
               if (apb_req.pwdata[1:0] == EN_ON) n.rx_en = 1'b1;
               if (apb_req.pwdata[1:0] == EN_OFF) n.rx_en = 1'b0;
               if (apb_req.pwdata[3:2] == EN_ON) n.tx_en = 1'b1;
               if (apb_req.pwdata[3:2] == EN_OFF) n.tx_en = 1'b0;
               if (apb_req.pwdata[6:4] == MISC_RTS_ON) n.rts_n = 1'b0;
               if (apb_req.pwdata[6:4] == MISC_RTS_OFF) n.rts_n = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // pop, then drain the waiting shift-register character
      if (done && !apb_req.pwrite && apb_req.paddr == ADDR_DATA && s_reg.pop_arm) begin
         n.fifo[0] = s_reg.fifo[1];
         n.fifo[1] = s_reg.fifo[2];
         n.cnt = s_reg.cnt - 2'h1;
         popped = 1'b1;
      end
      if (n.hold_v && n.cnt != FIFO_DEPTH) begin
         n.fifo[n.cnt] = n.hold;
         n.cnt = n.cnt + 2'h1;
         n.hold_v = 1'b0;
      end

      // receiver keeps listening while disabled in multidrop
      if (s_reg.tick) begin
         n.rsc = s_reg.rsc + 4'h1;
         unique case (s_reg.rst)
            R_IDLE: begin
               n.rsc = 4'h0;
               if ((s_reg.rx_en || multi) && !rx_in) n.rst = R_START;
            end
            R_START: begin
               if (s_reg.rsc == OVS_MID) begin
                  n.rsc = 4'h0;
                  n.rbits = 4'h0;
                  n.rst = rx_in ? R_IDLE : R_DATA;
                  start_ok = ~rx_in;
               end
            end
            R_DATA: begin
               if (s_reg.rsc == OVS_END) begin
                  n.rsh = {rx_in, s_reg.rsh[7:1]};
                  n.rbits = s_reg.rbits + 4'h1;
                  if (s_reg.rbits == BIT_LAST) n.rst = has9 ? R_PAR : R_STOP;
               end
            end
            R_PAR: begin
               if (s_reg.rsc == OVS_END) begin
                  n.rpar = rx_in;
                  n.rst = R_STOP;
               end
            end
            R_STOP: begin
               if (s_reg.rsc == OVS_END) begin
                  stop_ev = 1'b1;
                  n.rst = R_IDLE;
               end
            end
            R_BRK: begin
               if (rx_in) n.rst = R_IDLE;
            end
         endcase
      end

      if (start_ok) begin
         if (s_reg.hold_v && n.hold_v) begin
            n.hold_v = 1'b0;
            n.oe = 1'b1;
         end
         if (rts_rx_ctl && n.cnt == FIFO_DEPTH) n.rts_n = 1'b1;
      end

      if (stop_ev) begin
         e.data = s_reg.rsh;
         e.fe = ~rx_in;
         e.rb = ~rx_in && s_reg.rsh == 8'h00 && !(has9 && s_reg.rpar);
         if (multi) begin
            e.pe = s_reg.rpar;
         end else if (s_reg.mr1[4:3] == PM_PARITY) begin
            e.pe = (^{s_reg.rsh, s_reg.rpar}) ^ s_reg.mr1[MR1_PT];
         end else if (s_reg.mr1[4:3] == PM_FORCE) begin
            e.pe = s_reg.rpar ^ s_reg.mr1[MR1_PT];
         end
         if (s_reg.loop_act == LOOP_REMOTE) e.pe = 1'b0;
         accept = s_reg.loop_act != LOOP_REMOTE &&
                  (s_reg.rx_en || (multi && s_reg.rpar));
         if (accept) begin
            if (n.cnt != FIFO_DEPTH) begin
               n.fifo[n.cnt] = e;
               n.cnt = n.cnt + 2'h1;
            end else begin
               n.hold = e;
               n.hold_v = 1'b1;
            end
         end
         if (e.rb) n.rst = R_BRK;
      end

      if (rts_rx_ctl && s_reg.rts_n && n.cnt != FIFO_DEPTH &&
          !(done && apb_req.pwrite && apb_req.paddr == ADDR_CMD)) begin
         n.rts_n = 1'b0;
      end
      if ((popped && n.cnt != 2'h0) || (s_reg.cnt == 2'h0 && n.cnt != 2'h0)) begin
         n.acc = n.acc | {n.fifo[0].rb, n.fifo[0].fe, n.fifo[0].pe};
      end

      // loop selection; echo and remote leave only at a stop bit
      unique case (s_reg.aux[1:0])
         2'h0: req = LOOP_NONE;
         2'h1: req = LOOP_ECHO;
         2'h2: req = LOOP_LOCAL;
         2'h3: req = LOOP_REMOTE;
      endcase
      if (req == s_reg.loop_act) begin
         n.echo_wait = 1'b0;
      end else if (s_reg.loop_act == LOOP_REMOTE) begin
         if (stop_ev) n.loop_act = req;
      end else if (s_reg.loop_act == LOOP_ECHO) begin
         if (stop_ev) begin
            n.echo_wait = 1'b1;
            n.echo_cnt = HALF_BIT;
         end else if (s_reg.echo_wait && s_reg.tick) begin
            n.echo_cnt = s_reg.echo_cnt - 4'h1;
            if (s_reg.echo_cnt == 4'h1) begin
               n.loop_act = req;
               n.echo_wait = 1'b0;
            end
         end
      end else begin
         n.loop_act = req;
      end

      // transmitter; gets no new data while echo or remote own the line
      if (s_reg.tick) begin
         n.tsc = s_reg.tsc + 4'h1;
         unique case (s_reg.tst)
            T_IDLE: begin
               n.tsc = 4'h0;
               if (s_reg.tbuf_v && s_reg.tx_en) begin
                  n.tsh = s_reg.tbuf;
                  n.tbuf_v = 1'b0;
                  n.tpar = (s_reg.mr1[4:3] == PM_PARITY) ?
                     (^s_reg.tbuf) ^ s_reg.mr1[MR1_PT] : s_reg.mr1[MR1_PT];
                  n.tbits = 4'h0;
                  n.tst = T_START;
               end
            end
            T_START: if (s_reg.tsc == OVS_END) n.tst = T_DATA;
            T_DATA: begin
               if (s_reg.tsc == OVS_END) begin
                  n.tsh = {1'b0, s_reg.tsh[7:1]};
                  n.tbits = s_reg.tbits + 4'h1;
                  if (s_reg.tbits == BIT_LAST) n.tst = has9 ? T_PAR : T_STOP;
               end
            end
            T_PAR: if (s_reg.tsc == OVS_END) n.tst = T_STOP;
            T_STOP: if (s_reg.tsc == OVS_END) n.tst = T_IDLE;
         endcase
      end
      unique case (n.tst)
         T_IDLE: n.tline = 1'b1;
         T_START: n.tline = 1'b0;
         T_DATA: n.tline = n.tsh[0];
         T_PAR: n.tline = n.tpar;
         T_STOP: n.tline = 1'b1;
      endcase

      if (done && apb_req.pwrite && apb_req.paddr == ADDR_CMD) begin
         if (apb_req.pwdata[6:4] == MISC_RST_TX) begin
            n.tst = T_IDLE;
            n.tbuf_v = 1'b0;
            n.tx_en = 1'b0;
            n.tline = 1'b1;
         end
         if (apb_req.pwdata[6:4] == MISC_RST_RX) begin
            n.cnt = 2'h0;
            n.hold_v = 1'b0;
            n.oe = 1'b0;
            n.acc = 3'h0;
            n.rx_en = 1'b0;
            n.rts_n = 1'b1;
            n.rst = R_IDLE;
         end
      end

      unique case (n.loop_act)
         LOOP_LOCAL: n.txd = 1'b1;
         LOOP_ECHO, LOOP_REMOTE: n.txd = rx_in;
         default: n.txd = n.tline;
      endcase
      n.irq = (n.loop_act != LOOP_REMOTE) &&
              (n.mr1[MR1_IRQSEL] ? (n.cnt == FIFO_DEPTH) : (n.cnt != 2'h0));
      s_next = n;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
         s_reg.mr1 <= MODE1_RESET;
         s_reg.aux <= AUX_RESET;
         s_reg.loop_act <= LOOP_NONE;
         s_reg.rst <= R_IDLE;
         s_reg.tst <= T_IDLE;
         s_reg.rts_n <= 1'b1;
         s_reg.tline <= 1'b1;
         s_reg.txd <= 1'b1;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn || !ce);

   fifo_bound_a: assert property (s_reg.cnt <= FIFO_DEPTH)
      else $error("fifo count above depth");
   avail_flag_a: assert property (access && !s_reg.rsp.pready && !apb_req.pwrite &&
      apb_req.paddr == ADDR_STATUS && s_reg.loop_act != LOOP_REMOTE |=>
      apb_rsp.prdata[0] == ($past(s_reg.cnt) != 2'h0))
      else $error("char available flag wrong");
   full_flag_a: assert property (access && !s_reg.rsp.pready &&
      apb_req.paddr == ADDR_STATUS && s_reg.loop_act != LOOP_REMOTE |=>
      apb_rsp.prdata[1] == ($past(s_reg.cnt) == FIFO_DEPTH))
      else $error("fifo full flag wrong");
   head_read_a: assert property (access && !s_reg.rsp.pready && apb_req.paddr == ADDR_DATA &&
      s_reg.cnt != 2'h0 && s_reg.loop_act != LOOP_REMOTE |=>
      apb_rsp.prdata[7:0] == $past(s_reg.fifo[0].data))
      else $error("buffer read not oldest entry");
   status_nopop_a: assert property (done && !apb_req.pwrite &&
      apb_req.paddr == ADDR_STATUS |=> s_reg.cnt >= $past(s_reg.cnt))
      else $error("status read changed fifo");
   irq_source_a: assert property (s_reg.irq == (s_reg.loop_act != LOOP_REMOTE &&
      (s_reg.mr1[MR1_IRQSEL] ? s_reg.cnt == FIFO_DEPTH : s_reg.cnt != 2'h0)))
      else $error("interrupt source mismatch");
   overrun_flag_a: assert property (start_ok && s_reg.hold_v && !done |=> s_reg.oe)
      else $error("overrun not flagged");
   rts_negate_a: assert property (start_ok && rts_rx_ctl && s_reg.cnt == FIFO_DEPTH &&
      !done |=> s_reg.rts_n)
      else $error("rts not negated on full");
   rts_both_a: assert property (s_reg.mr1[MR1_RXRTS] && s_reg.aux[AUX_TXRTS] && !done
      |=> s_reg.rts_n == $past(s_reg.rts_n))
      else $error("rts moved with both controls set");
   rx_reset_a: assert property (done && apb_req.pwrite && apb_req.paddr == ADDR_CMD &&
      apb_req.pwdata[6:4] == MISC_RST_RX |=> s_reg.cnt == 2'h0 && !s_reg.irq &&
      s_reg.rts_n && !s_reg.rx_en)
      else $error("receiver reset incomplete");
   local_mark_a: assert property (s_reg.loop_act == LOOP_LOCAL |-> s_reg.txd)
      else $error("txd not marking in local loop");
   remote_quiet_a: assert property (access && !s_reg.rsp.pready &&
      s_reg.loop_act == LOOP_REMOTE && apb_req.paddr == ADDR_STATUS |=>
      apb_rsp.prdata == 32'h0000_0000)
      else $error("status active in remote loop");
endmodule

/* uart_rx_fifo_loop_bench.sv */
/*
 * self-checking bench for the receive fifo, error modes, flow control,
 * loop modes and multidrop tagging.
 * assumes serial_peer drives rxd and the design answers apb in 2 access cycles.
 */
module uart_rx_fifo_loop_bench import uart_rx_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   // tx flags excluded: their value with the transmitter idle is not pinned down
   localparam logic [31:0] ST_MASK = 32'hf3;
   logic ref_clk;
   logic resetn;
   logic rxd;
   logic txd;
   logic rts_n;
   logic rx_irq;
   logic echo_chk = 1'b0;
   logic rxd_q = 1'b1;
   apb_req_t apb_req;
   apb_rsp_t apb_rsp;
   int n_fail = 0;
   int check_count = 0;

   uart_rx_fifo_loop i_dut (.ref_clk(ref_clk), .resetn(resetn), .ce(1'b1),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .rxd(rxd), .txd(txd), .rts_n(rts_n),
      .rx_irq(rx_irq));
   serial_peer i_peer (.ref_clk(ref_clk), .rxd(rxd));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic chk1(input string w, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %b seen %b", w, e, g);
      end
   endtask

   // request held until pready is seen at an edge; released at that edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         input logic err, output logic [31:0] r);
      int n;
      @(posedge ref_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      r = apb_rsp.prdata;
      chk1("pready", 1'b1, apb_rsp.pready);
      chk1("pslverr", err, apb_rsp.pslverr);
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, {24'h0, d}, 1'b0, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
         input string w);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, 1'b0, r);
      chk(w, e, r & m);
   endtask

   task automatic snd(input logic [7:0] d);
      i_peer.send(d, 1'b0, 1'b0, 1'b1);
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   // echo and remote loop: txd follows rxd one cycle later
   always @(posedge ref_clk) begin
      if (echo_chk) begin
         chk1("txd echo", rxd_q, txd);
      end
      rxd_q <= rxd;
   end

   task automatic t_reset;
      logic [31:0] r;
      rd(ADDR_MODE1, 32'hff, {24'h0, MODE1_RESET}, "mode1");
      rd(ADDR_AUX, 32'hff, {24'h0, AUX_RESET}, "aux");
      rd(ADDR_STATUS, ST_MASK, 32'h0, "status");
      chk1("rts_n", 1'b1, rts_n);
      bus(1'b0, 8'h14, 32'h0, 1'b1, r);
      chk("unmapped", 32'h0, r);
      done("reset");
   endtask

   task automatic t_fifo;
      wr(ADDR_MODE1, 8'hd0);
      wr(ADDR_CMD, 8'h01);
      chk1("rts_n", 1'b0, rts_n);
      for (int i = 0; i < 3; i++) begin
         snd(8'ha0 + 8'(i));
         chk1("rx_irq", i == 2, rx_irq);
      end
      rd(ADDR_STATUS, ST_MASK, 32'h03, "status full");
      snd(8'ha3);
      chk1("rts_n", 1'b1, rts_n);
      // a further start while one waits in the shift register drops it
      snd(8'ha4);
      rd(ADDR_STATUS, ST_MASK, 32'h13, "status ovr");
      rd(ADDR_STATUS, ST_MASK, 32'h13, "status again");
      for (int i = 0; i < 3; i++) begin
         rd(ADDR_DATA, 32'hff, 32'ha0 + i, "data");
      end
      chk1("rts_n", 1'b0, rts_n);
      wr(ADDR_CMD, 8'h02);
      rd(ADDR_DATA, 32'hff, 32'ha4, "data held");
      rd(ADDR_STATUS, 32'h01, 32'h0, "avail");
      done("fifo");
   endtask

   task automatic t_errmode;
      wr(ADDR_MODE1, 8'h10);
      wr(ADDR_CMD, 8'h31);
      i_peer.send(8'h5a, 1'b0, 1'b0, 1'b0);
      i_peer.send(8'h00, 1'b0, 1'b0, 1'b0);
      snd(8'h33);
      rd(ADDR_STATUS, ST_MASK, 32'h43, "st framing");
      rd(ADDR_DATA, 32'hff, 32'h5a, "data");
      // a break also has a low stop bit, so framing is flagged with it
      rd(ADDR_STATUS, ST_MASK, 32'hc1, "st break");
      rd(ADDR_DATA, 32'hff, 32'h00, "data");
      rd(ADDR_STATUS, ST_MASK, 32'h01, "st clean");
      rd(ADDR_DATA, 32'hff, 32'h33, "data");
      wr(ADDR_MODE1, 8'h30);
      // restart accumulation: earlier heads carried framing and break
      wr(ADDR_CMD, 8'h30);
      i_peer.send(8'h71, 1'b0, 1'b0, 1'b0);
      snd(8'h72);
      rd(ADDR_STATUS, ST_MASK, 32'h41, "blk head");
      rd(ADDR_DATA, 32'hff, 32'h71, "data");
      rd(ADDR_STATUS, ST_MASK, 32'h41, "blk accum");
      rd(ADDR_DATA, 32'hff, 32'h72, "data");
      wr(ADDR_CMD, 8'h30);
      rd(ADDR_STATUS, ST_MASK, 32'h00, "blk clear");
      done("errmode");
   endtask

   task automatic t_multi;
      wr(ADDR_MODE1, 8'h18);
      wr(ADDR_CMD, 8'h02);
      i_peer.send(8'h11, 1'b1, 1'b0, 1'b1);
      rd(ADDR_STATUS, ST_MASK, 32'h00, "md data off");
      i_peer.send(8'h22, 1'b1, 1'b1, 1'b1);
      rd(ADDR_STATUS, ST_MASK, 32'h21, "md addr");
      chk1("rx_irq", 1'b1, rx_irq);
      rd(ADDR_DATA, 32'hff, 32'h22, "md data");
      wr(ADDR_CMD, 8'h01);
      i_peer.send(8'h44, 1'b1, 1'b0, 1'b1);
      rd(ADDR_STATUS, ST_MASK, 32'h01, "md data on");
      rd(ADDR_DATA, 32'hff, 32'h44, "md data");
      done("multidrop");
   endtask

   task automatic t_rxreset;
      // both rts controls on: the receiver must no longer reassert rts
      wr(ADDR_MODE1, 8'h90);
      wr(ADDR_AUX, 8'h04);
      snd(8'h55);
      chk1("rx_irq", 1'b1, rx_irq);
      wr(ADDR_CMD, 8'h10);
      rd(ADDR_STATUS, ST_MASK, 32'h00, "after reset");
      chk1("rx_irq", 1'b0, rx_irq);
      chk1("rts_n", 1'b1, rts_n);
      snd(8'h66);
      rd(ADDR_STATUS, ST_MASK, 32'h00, "not enabled");
      done("rxreset");
   endtask

   task automatic t_loops;
      logic [31:0] r;
      int n;
      wr(ADDR_AUX, 8'h02);
      wr(ADDR_CMD, 8'h05);
      wr(ADDR_DATA, 8'hc3);
      // traffic on the pin must not reach the receiver here
      fork
         i_peer.send(8'h0f, 1'b0, 1'b0, 1'b1);
         begin
            n = 0;
            do begin
               bus(1'b0, ADDR_STATUS, 32'h0, 1'b0, r);
               chk1("txd mark", 1'b1, txd);
               n++;
            end while (r[0] !== 1'b1 && n < 1000);
         end
      join
      rd(ADDR_DATA, 32'hff, 32'hc3, "local data");
      rd(ADDR_STATUS, ST_MASK, 32'h00, "local one");
      wr(ADDR_AUX, 8'h01);
      echo_chk = 1'b1;
      wr(ADDR_DATA, 8'hff);
      snd(8'h96);
      echo_chk = 1'b0;
      rd(ADDR_DATA, 32'hff, 32'h96, "echo data");
      rd(ADDR_STATUS, 32'h0c, 32'h00, "echo tx flags");
      wr(ADDR_AUX, 8'h03);
      echo_chk = 1'b1;
      snd(8'h3c);
      echo_chk = 1'b0;
      rd(ADDR_STATUS, 32'hff, 32'h00, "remote st");
      rd(ADDR_DATA, 32'hff, 32'h00, "remote data");
      chk1("rx_irq", 1'b0, rx_irq);
      done("loops");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // about 20 frames of 1760 or 1920 cycles plus bus traffic
   initial begin
      repeat (80000) @(posedge ref_clk);
      n_fail++;
      conclude();
   end

   initial begin
      resetn = 1'b0;
      apb_req = '0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      t_reset();
      t_fifo();
      t_errmode();
      t_multi();
      t_rxreset();
      t_loops();
      conclude();
   end
endmodule

/* uart_rx_pkg.sv */
/*
 * constants, carriers and types for the receive fifo / loop / multidrop block.
 * assumes an apb master on ref_clk and a serial peer on rxd/txd/rts_n.
 */
package uart_rx_pkg;
   localparam logic [7:0] ADDR_MODE1 = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CMD = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0c;
   localparam logic [7:0] ADDR_AUX = 8'h10;
   localparam int MR1_RXRTS = 7;
   localparam int MR1_IRQSEL = 6;
   localparam int MR1_BLOCK = 5;
   localparam int MR1_PT = 2;
   localparam int AUX_TXRTS = 2;
   localparam logic [1:0] PM_PARITY = 2'h0;
   localparam logic [1:0] PM_FORCE = 2'h1;
   localparam logic [1:0] PM_NONE = 2'h2;
   localparam logic [1:0] PM_MULTI = 2'h3;
   localparam logic [1:0] EN_ON = 2'h1;
   localparam logic [1:0] EN_OFF = 2'h2;
   localparam logic [2:0] MISC_RST_RX = 3'h1;
   localparam logic [2:0] MISC_RST_TX = 3'h2;
   localparam logic [2:0] MISC_RST_ERR = 3'h3;
   localparam logic [2:0] MISC_RTS_ON = 3'h4;
   localparam logic [2:0] MISC_RTS_OFF = 3'h5;
   localparam logic [1:0] FIFO_DEPTH = 2'h3;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] OVS_MID = 4'h7;
   localparam logic [3:0] OVS_END = 4'hf;
   localparam logic [3:0] HALF_BIT = 4'h8;
   localparam int CLK_HZ = 20_000_000;
   localparam int BAUD_HZ = 115_200;
   localparam logic [3:0] DIV16 = 4'((CLK_HZ / (BAUD_HZ * 16)) - 1);
   localparam logic [7:0] MODE1_RESET = 8'h00;
   localparam logic [7:0] AUX_RESET = 8'h00;

   typedef enum logic [1:0] {LOOP_NONE, LOOP_ECHO, LOOP_LOCAL, LOOP_REMOTE} loop_t;
   typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_BRK} rx_state_t;
   typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_state_t;
   typedef struct packed {
      logic rb;
      logic fe;
      logic pe;
      logic [7:0] data;
   } entry_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;
endpackage
